/* File: src/pll_status_pkg.sv */
// Purpose: constants and carriers for the pll status readback bank
// Assumes: register index = byte address / 4
// Notes: the status word mirrors live pll conditions
//
// Function
// - holdover enabled only when both enable bits set
// - bit 6 reports vco calibration finished
// - bit 5 reports holdover state actually active
// - bit 4 set when secondary reference selected
// - bit 3 set when vco above threshold
// - bit 2 set when secondary above threshold
// - bit 1 set when primary above threshold
// - bit 0 reports digital lock detect
// - status register is read only, live values
// - config bit 4 disables status readback
// - config bit 1 selects external holdover control
// - reference bit 0 selects differential mode
package pll_status_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam int ADR_W = 12;
    localparam int IDX_W = 10;
    localparam logic [IDX_W-1:0] IDX_MON_CFG = 10'h01a;
    localparam logic [IDX_W-1:0] IDX_REF_CFG = 10'h01c;
    localparam logic [IDX_W-1:0] IDX_HOLD_CFG = 10'h01d;
    localparam logic [IDX_W-1:0] IDX_PLL_STATUS = 10'h01f;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h040;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h041;
    // ****************************************
    // field positions and widths
    // ****************************************
    localparam int STATUS_W = 7;
    localparam int HOLD_CFG_W = 5;
    localparam int REF_CFG_W = 2;
    localparam int HOLD_EN_B_BIT = 0;
    localparam int HOLD_EXT_BIT = 1;
    localparam int HOLD_EN_A_BIT = 2;
    localparam int LD_CMP_BIT = 3;
    localparam int STAT_DIS_BIT = 4;
    localparam int REF_DIFF_BIT = 0;
    localparam int REF_PWR_BIT = 1;
    localparam int MON_THR_BIT = 6;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [HOLD_CFG_W-1:0] HOLD_CFG_RST = 5'h00;
    localparam logic [REF_CFG_W-1:0] REF_CFG_RST = 2'h0;
    localparam logic MON_THR_RST = 1'h0;
    localparam logic [STATUS_W-1:0] IRQ_MASK_RST = 7'h00;
    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic cal_done;
        logic holdover_active;
        logic secondary_selected;
        logic vco_above;
        logic secondary_above;
        logic primary_above;
        logic locked;
    } status_t;
    typedef struct packed {
        logic holdover_enable;
        logic holdover_auto;
        logic holdover_external;
        logic ld_comparator_enable;
        logic differential_mode;
        logic primary_power_on;
        logic switchover_allowed;
        logic threshold_select;
    } cfg_t;
endpackage

/* File: src/status_sampler.sv */
// Purpose: registers live status bits and flags each change
// Assumes: inputs synchronous to clk_i
// Notes: change pulses feed the interrupt bank
`timescale 1ns/1ps
module status_sampler import pll_status_pkg::*; #(
    parameter int WIDTH = STATUS_W
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // live and sampled status
    input wire logic [WIDTH-1:0] live_i,
    output logic [WIDTH-1:0] stat_o,
    output logic [WIDTH-1:0] change_o
);
    typedef struct packed {
        logic [WIDTH-1:0] stat;
        logic [WIDTH-1:0] chg;
    } smp_state_t;
    smp_state_t st;
    smp_state_t next_st;
    logic [WIDTH-1:0] next_st_chg_bit;
    if (WIDTH < 1) begin : g_chk
        $error("status_sampler needs at least one bit");
    end
    always_comb begin
        next_st = st;
        next_st.stat = live_i;
        next_st.chg = next_st_chg_bit;
    end
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        assign next_st_chg_bit[i] = live_i[i] ^ st.stat[i];
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign stat_o = st.stat;
    assign change_o = st.chg;
endmodule

/* File: src/irq_bank.sv */
// Purpose: sticky event bits, mask, level interrupt
// Assumes: write strobes last one cycle
// Notes: a set in the clearing cycle wins
`timescale 1ns/1ps
module irq_bank import pll_status_pkg::*; #(
    parameter int WIDTH = STATUS_W
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // events and software access
    input wire logic [WIDTH-1:0] event_i,
    input wire logic clear_we_i,
    input wire logic mask_we_i,
    input wire logic [WIDTH-1:0] wdata_i,
    // state
    output logic [WIDTH-1:0] pend_o,
    output logic [WIDTH-1:0] mask_o,
    output logic irq_o
);
    typedef struct packed {
        logic [WIDTH-1:0] pend;
        logic [WIDTH-1:0] mask;
    } irq_state_t;
    irq_state_t st;
    irq_state_t next_st;
    if (WIDTH != STATUS_W) begin : g_chk
        $error("irq_bank width must match the status word");
    end
    always_comb begin
        next_st = st;
        if (clear_we_i) begin
            next_st.pend = st.pend & ~wdata_i;
        end
        next_st.pend = next_st.pend | event_i;
        if (mask_we_i) begin
            next_st.mask = wdata_i;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '{pend: '0, mask: IRQ_MASK_RST};
        end else begin
            st <= next_st;
        end
    end
    assign pend_o = st.pend;
    assign mask_o = st.mask;
    assign irq_o = |(st.pend & st.mask);
endmodule

/* File: src/pll_status_readback.sv */
// Purpose: pll status readback and holdover/reference configuration
// Assumes: classic wishbone slave, one byte of data per word
// Notes: ack follows a request by one cycle, writes land at ack
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
module pll_status_readback import pll_status_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // live pll conditions
    input wire status_t status_i,
    // configuration to pll and holdover logic
    output cfg_t cfg_o,
    // interrupt
    output logic irq_o
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic [HOLD_CFG_W-1:0] hold_cfg;
        logic [REF_CFG_W-1:0] ref_cfg;
        logic mon_thr;
        cfg_t cfg;
    } bank_state_t;
    bank_state_t st;
    bank_state_t next_st;
    logic [STATUS_W-1:0] stat_q;
    logic [STATUS_W-1:0] stat_chg;
    logic [STATUS_W-1:0] irq_pend;
    logic [STATUS_W-1:0] irq_mask;
    logic [IDX_W-1:0] idx;
    logic req;
    logic wr;
    logic wr_lane0;
    logic irq_clear_we;
    logic irq_mask_we;
    logic idx_mapped;
    // ****************************************
    // status sampling and interrupts
    // ****************************************
    status_sampler #(
        .WIDTH(STATUS_W)
    ) u_sampler (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .live_i(status_i),
        .stat_o(stat_q),
        .change_o(stat_chg)
    );
    irq_bank #(
        .WIDTH(STATUS_W)
    ) u_irq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .event_i(stat_chg),
        .clear_we_i(irq_clear_we),
        .mask_we_i(irq_mask_we),
        .wdata_i(wb_dat_i[STATUS_W-1:0]),
        .pend_o(irq_pend),
        .mask_o(irq_mask),
        .irq_o(irq_o)
    );
    // ****************************************
    // bus decode
    // ****************************************
    assign idx = wb_adr_i[ADR_W-1:2];
    assign req = wb_cyc_i & wb_stb_i;
    assign wr = req & wb_we_i & st.ack;
    assign wr_lane0 = wr & wb_sel_i[0];
    assign irq_clear_we = wr_lane0 && (idx == IDX_IRQ_STATUS);
    assign irq_mask_we = wr_lane0 && (idx == IDX_IRQ_MASK);
    assign idx_mapped = (idx == IDX_MON_CFG) || (idx == IDX_REF_CFG) || (idx == IDX_HOLD_CFG)
        || (idx == IDX_PLL_STATUS) || (idx == IDX_IRQ_STATUS) || (idx == IDX_IRQ_MASK);
    if (STATUS_W > 8 || HOLD_CFG_W > 8 || MON_THR_BIT > 7) begin : g_chk
        $error("configuration fields must fit in the data byte");
    end
    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_st = st;
        next_st.ack = req & ~st.ack;
        if (req && !st.ack) begin
            next_st.dat = 32'h0000_0000;
            unique case (idx)
                IDX_PLL_STATUS: begin
                    if (!st.hold_cfg[STAT_DIS_BIT]) begin
                        next_st.dat[STATUS_W-1:0] = stat_q;
                    end
                end
                IDX_HOLD_CFG: begin
                    next_st.dat[HOLD_CFG_W-1:0] = st.hold_cfg;
                end
                IDX_REF_CFG: begin
                    next_st.dat[REF_CFG_W-1:0] = st.ref_cfg;
                end
                IDX_MON_CFG: begin
                    next_st.dat[MON_THR_BIT] = st.mon_thr;
                end
                IDX_IRQ_STATUS: begin
                    next_st.dat[STATUS_W-1:0] = irq_pend;
                end
                IDX_IRQ_MASK: begin
                    next_st.dat[STATUS_W-1:0] = irq_mask;
                end
                default: begin
                    next_st.dat = 32'h0000_0000;
                end
            endcase
        end
        // status index has no write path at all
        if (wr_lane0) begin
            unique case (idx)
                IDX_HOLD_CFG: begin
                    next_st.hold_cfg = wb_dat_i[HOLD_CFG_W-1:0];
                end
                IDX_REF_CFG: begin
                    next_st.ref_cfg = wb_dat_i[REF_CFG_W-1:0];
                end
                IDX_MON_CFG: begin
                    next_st.mon_thr = wb_dat_i[MON_THR_BIT];
                end
                default: begin
                    next_st.mon_thr = next_st.mon_thr;
                end
            endcase
        end
        // configuration decoded from the stored bits
        next_st.cfg.holdover_enable = next_st.hold_cfg[HOLD_EN_A_BIT] & next_st.hold_cfg[HOLD_EN_B_BIT];
        next_st.cfg.holdover_auto = next_st.cfg.holdover_enable & ~next_st.hold_cfg[HOLD_EXT_BIT];
        next_st.cfg.holdover_external = next_st.cfg.holdover_enable & next_st.hold_cfg[HOLD_EXT_BIT];
        next_st.cfg.ld_comparator_enable = next_st.hold_cfg[LD_CMP_BIT];
        next_st.cfg.differential_mode = next_st.ref_cfg[REF_DIFF_BIT];
        next_st.cfg.switchover_allowed = ~next_st.ref_cfg[REF_DIFF_BIT];
        next_st.cfg.primary_power_on = next_st.ref_cfg[REF_PWR_BIT];
        next_st.cfg.threshold_select = next_st.mon_thr;
    end
    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
            st.hold_cfg <= HOLD_CFG_RST;
            st.ref_cfg <= REF_CFG_RST;
            st.mon_thr <= MON_THR_RST;
            st.cfg.switchover_allowed <= ~REF_CFG_RST[REF_DIFF_BIT];
        end else begin
            st <= next_st;
        end
    end
    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.dat;
    assign cfg_o = st.cfg;
    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [31:0] past_wdat;
    logic past_hold_wr;
    logic past_status_wr;
    logic past_ref_wr;
    logic past_mon_wr;
    logic past_rb_on;
    logic rd_ack;
    logic status_rd;
    status_t rd_status;
    // helpers hold each write and its data one edge after it lands
    always_ff @(posedge clk_i) begin
        past_wdat <= wb_dat_i;
        past_hold_wr <= wr_lane0 && (idx == IDX_HOLD_CFG);
        past_status_wr <= wr && (idx == IDX_PLL_STATUS);
        past_ref_wr <= wr_lane0 && (idx == IDX_REF_CFG);
        past_mon_wr <= wr_lane0 && (idx == IDX_MON_CFG);
        past_rb_on <= !st.hold_cfg[STAT_DIS_BIT];
    end
    assign rd_ack = wb_ack_o && !wb_we_i;
    assign status_rd = rd_ack && (idx == IDX_PLL_STATUS);
    // the returned byte seen through the status carrier
    assign rd_status = status_t'(wb_dat_o[STATUS_W-1:0]);
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");
    chk_ack_next_cycle: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    chk_hold_enable_pair: assert property (past_hold_wr |->
        cfg_o.holdover_enable == (past_wdat[HOLD_EN_A_BIT] && past_wdat[HOLD_EN_B_BIT]))
        else $error("holdover enable not the and of both bits");
    chk_hold_mode_split: assert property (cfg_o.holdover_enable |->
        (cfg_o.holdover_auto != cfg_o.holdover_external))
        else $error("holdover mode not exclusive");
    chk_status_readback: assert property (wb_ack_o && !wb_we_i && idx == IDX_PLL_STATUS
        && !$past(st.hold_cfg[STAT_DIS_BIT]) |-> wb_dat_o == {25'h0, $past(stat_q)})
        else $error("status readback mismatch");
    chk_live_status: assert property (##1 stat_q == $past(status_i))
        else $error("status not following live conditions");
    chk_readback_off: assert property (wb_ack_o && !wb_we_i && idx == IDX_PLL_STATUS
        && $past(st.hold_cfg[STAT_DIS_BIT]) |-> wb_dat_o == 32'h0000_0000)
        else $error("disabled status readback not zero");
    chk_status_ro_write: assert property (past_status_wr |-> $stable(cfg_o))
        else $error("status write changed configuration");
    chk_diff_switchover: assert property (cfg_o.switchover_allowed != cfg_o.differential_mode)
        else $error("switchover allowed in differential mode");
    chk_unmapped_zero: assert property (rd_ack && !idx_mapped |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    // ****************************************
    // bus checks
    // ****************************************
    chk_read_upper_zero: assert property (rd_ack |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data above the low byte not zero");
    chk_read_data_held: assert property (rd_ack |=> $stable(wb_dat_o))
        else $error("read data changed right after ack");
    chk_no_stray_ack: assert property (!req |=> !wb_ack_o)
        else $error("ack without a request");
    chk_reset_state: assert property ($fell(rst_i) |-> !wb_ack_o && !irq_o
        && cfg_o.switchover_allowed == !REF_CFG_RST[REF_DIFF_BIT])
        else $error("outputs not at reset values");
    chk_status_write_inert: assert property (past_status_wr |-> $stable(irq_mask) && $stable(st.hold_cfg))
        else $error("status write changed a stored register");
    chk_hold_cfg_read: assert property (rd_ack && idx == IDX_HOLD_CFG |->
        wb_dat_o[HOLD_CFG_W-1:0] == $past(st.hold_cfg))
        else $error("holdover configuration readback wrong");
    chk_ref_cfg_read: assert property (rd_ack && idx == IDX_REF_CFG |->
        wb_dat_o[REF_CFG_W-1:0] == $past(st.ref_cfg))
        else $error("reference configuration readback wrong");
    chk_mon_cfg_read: assert property (rd_ack && idx == IDX_MON_CFG |->
        wb_dat_o[MON_THR_BIT] == $past(st.mon_thr))
        else $error("monitor configuration readback wrong");
    chk_mask_read: assert property (rd_ack && idx == IDX_IRQ_MASK |->
        wb_dat_o[STATUS_W-1:0] == $past(irq_mask))
        else $error("mask readback wrong");
    chk_pend_read: assert property (rd_ack && idx == IDX_IRQ_STATUS |->
        wb_dat_o[STATUS_W-1:0] == $past(irq_pend))
        else $error("pending readback wrong");
    // ****************************************
    // status field checks
    // ****************************************
    chk_field_cal_done: assert property (status_rd && past_rb_on |->
        rd_status.cal_done == $past(status_i.cal_done, 2))
        else $error("calibration finished bit wrong");
    chk_field_holdover_active: assert property (status_rd && past_rb_on |->
        rd_status.holdover_active == $past(status_i.holdover_active, 2))
        else $error("holdover active bit wrong");
    chk_field_secondary_selected: assert property (status_rd && past_rb_on |->
        rd_status.secondary_selected == $past(status_i.secondary_selected, 2))
        else $error("reference selected bit wrong");
    chk_field_vco_above: assert property (status_rd && past_rb_on |->
        rd_status.vco_above == $past(status_i.vco_above, 2))
        else $error("vco threshold bit wrong");
    chk_field_secondary_above: assert property (status_rd && past_rb_on |->
        rd_status.secondary_above == $past(status_i.secondary_above, 2))
        else $error("secondary threshold bit wrong");
    chk_field_primary_above: assert property (status_rd && past_rb_on |->
        rd_status.primary_above == $past(status_i.primary_above, 2))
        else $error("primary threshold bit wrong");
    chk_field_locked: assert property (status_rd && past_rb_on |->
        rd_status.locked == $past(status_i.locked, 2))
        else $error("lock detect bit wrong");
    // ****************************************
    // configuration checks
    // ****************************************
    chk_hold_external: assert property (past_hold_wr |-> cfg_o.holdover_external
        == (past_wdat[HOLD_EN_A_BIT] && past_wdat[HOLD_EN_B_BIT] && past_wdat[HOLD_EXT_BIT]))
        else $error("external holdover mode wrong");
    chk_hold_auto: assert property (past_hold_wr |-> cfg_o.holdover_auto
        == (past_wdat[HOLD_EN_A_BIT] && past_wdat[HOLD_EN_B_BIT] && !past_wdat[HOLD_EXT_BIT]))
        else $error("automatic holdover mode wrong");
    chk_ld_comparator: assert property (past_hold_wr |-> cfg_o.ld_comparator_enable == past_wdat[LD_CMP_BIT])
        else $error("lock detect comparator enable wrong");
    chk_ref_mode: assert property (past_ref_wr |-> cfg_o.differential_mode == past_wdat[REF_DIFF_BIT])
        else $error("reference mode wrong");
    chk_primary_power: assert property (past_ref_wr |-> cfg_o.primary_power_on == past_wdat[REF_PWR_BIT])
        else $error("primary reference power bit wrong");
    chk_threshold_select: assert property (past_mon_wr |->
        cfg_o.threshold_select == past_wdat[MON_THR_BIT])
        else $error("threshold select wrong");
    chk_cfg_write_only: assert property ($changed(cfg_o) |-> $past(wr_lane0))
        else $error("configuration changed without a write");
    // ****************************************
    // interrupt checks
    // ****************************************
    // any change of a status bit is an event and beats a clear
    chk_irq_event_sets: assert property (|stat_chg |=> (irq_pend & $past(stat_chg)) == $past(stat_chg))
        else $error("status change did not set its pending bit");
    chk_irq_clear_ones: assert property (irq_clear_we |=>
        (irq_pend & $past(wb_dat_i[STATUS_W-1:0] & ~stat_chg)) == '0)
        else $error("pending bit survived its clear");
    chk_irq_mask_write: assert property (irq_mask_we |=> irq_mask == $past(wb_dat_i[STATUS_W-1:0]))
        else $error("mask write not stored");
    chk_irq_masked_quiet: assert property (irq_mask == '0 |-> !irq_o)
        else $error("interrupt raised with every bit masked");
    // ****************************************
    // coverage
    // ****************************************
    cov_status_read: cover property (wb_ack_o && !wb_we_i && idx == IDX_PLL_STATUS && wb_dat_o[0]);
    cov_holdover_on: cover property (past_hold_wr ##0 cfg_o.holdover_enable);
    cov_irq_raise: cover property (!irq_o ##1 irq_o);
    cov_readback_off: cover property (wb_ack_o && idx == IDX_PLL_STATUS && st.hold_cfg[STAT_DIS_BIT]);
    cov_external_hold: cover property (past_hold_wr ##0 cfg_o.holdover_external);
endmodule

/* File: verif/pll_status_readback_test.sv */
// Purpose: self-checking bench for the pll status readback bank
// Assumes: ack one cycle after a request is taken, status seen in reads after two edges
// Notes: stimulus at the rising edge, results compared with case equality
`timescale 1ns/1ps
module pll_status_readback_test;
    import pll_status_pkg::*;
    // ****************************************
    // signals and design
    // ****************************************
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [ADR_W-1:0] adr = '0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    status_t status = '0;
    cfg_t cfg;
    logic irq;
    logic [31:0] got;
    int failures = 0;
    int samples_checked = 0;

    pll_status_readback dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .status_i(status), .cfg_o(cfg), .irq_o(irq)
    );

    initial begin
        forever #10 clk_i = ~clk_i;
    end
    // ****************************************
    // bus tasks and compares
    // ****************************************
    task automatic report_and_stop();
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic bus_cycle(input logic w, input logic [IDX_W-1:0] idx, input logic [3:0] s,
                             input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= s;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        got = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 20) begin
            $display("CHECK FAILED %0t no acknowledge", $time);
            failures++;
            report_and_stop();
        end
    endtask

    task automatic compare_word(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
        bus_cycle(1'b0, idx, 4'h0, 8'h00);
        samples_checked++;
        if (got !== exp) begin
            $display("CHECK FAILED %0t read %h got %h want %h", $time, idx, got, exp);
            failures++;
        end
    endtask

    task automatic compare_cfg(input logic [7:0] exp);
        @(negedge clk_i);
        samples_checked++;
        if (cfg !== exp) begin
            $display("CHECK FAILED %0t cfg got %h want %h", $time, cfg, exp);
            failures++;
        end
    endtask

    task automatic compare_irq(input logic exp);
        @(negedge clk_i);
        samples_checked++;
        if (irq !== exp) begin
            $display("CHECK FAILED %0t irq got %b want %b", $time, irq, exp);
            failures++;
        end
    endtask
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        compare_cfg(8'h02);
        compare_irq(1'b0);
        // one status bit at a time, then a write that must not stick
        for (int i = 0; i < STATUS_W; i++) begin
            @(posedge clk_i);
            status <= status_t'(7'h01 << i);
            repeat (3) @(posedge clk_i);
            compare_word(IDX_PLL_STATUS, 32'h1 << i);
        end
        bus_cycle(1'b1, IDX_PLL_STATUS, 4'hf, 8'hff);
        compare_word(IDX_PLL_STATUS, 32'h40);
        // holdover enable pair and external control, written while the calibration finished bit is set
        bus_cycle(1'b1, IDX_HOLD_CFG, 4'h1, 8'h05);
        compare_cfg(8'hc2);
        bus_cycle(1'b1, IDX_HOLD_CFG, 4'h1, 8'h07);
        compare_cfg(8'ha2);
        bus_cycle(1'b1, IDX_HOLD_CFG, 4'h1, 8'h04);
        compare_cfg(8'h02);
        bus_cycle(1'b1, IDX_HOLD_CFG, 4'h0, 8'h05);
        compare_cfg(8'h02);
        bus_cycle(1'b1, IDX_HOLD_CFG, 4'h1, 8'h09);
        compare_cfg(8'h12);
        // readback disable hides the status word
        bus_cycle(1'b1, IDX_HOLD_CFG, 4'h1, 8'h10);
        compare_word(IDX_PLL_STATUS, 32'h0);
        compare_word(IDX_HOLD_CFG, 32'h10);
        bus_cycle(1'b1, IDX_HOLD_CFG, 4'h1, 8'h00);
        compare_word(IDX_PLL_STATUS, 32'h40);
        // reference mode, power and threshold select
        bus_cycle(1'b1, IDX_REF_CFG, 4'h1, 8'h01);
        compare_cfg(8'h08);
        bus_cycle(1'b1, IDX_REF_CFG, 4'h1, 8'h02);
        compare_cfg(8'h06);
        bus_cycle(1'b1, IDX_MON_CFG, 4'h1, 8'h40);
        compare_cfg(8'h07);
        compare_word(IDX_MON_CFG, 32'h40);
        compare_word(10'h100, 32'h0);
        // interrupt: every bit changed above, mask in, clear, retrigger, mask out
        compare_word(IDX_IRQ_STATUS, 32'h7f);
        compare_irq(1'b0);
        bus_cycle(1'b1, IDX_IRQ_MASK, 4'h1, 8'h7f);
        compare_irq(1'b1);
        bus_cycle(1'b1, IDX_IRQ_STATUS, 4'h1, 8'h7f);
        compare_irq(1'b0);
        compare_word(IDX_IRQ_STATUS, 32'h0);
        @(posedge clk_i);
        status <= status_t'(7'h41);
        repeat (3) @(posedge clk_i);
        compare_irq(1'b1);
        compare_word(IDX_IRQ_STATUS, 32'h01);
        bus_cycle(1'b1, IDX_IRQ_MASK, 4'h1, 8'h00);
        compare_irq(1'b0);
        compare_word(IDX_IRQ_STATUS, 32'h01);
        compare_word(IDX_IRQ_MASK, 32'h0);
        report_and_stop();
    end
endmodule
